// >>> dv/timer2_capture_reload_compare_props.sv
module timer2_capture_reload_compare_props
#(
  parameter int TICK_DIV = 1 // Clocks per tick
)
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp // Response
);
  // ==========================================================
  // Read address phase decode
  // ==========================================================
  logic rd_take;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Read of one register index taken
  sequence s_rd(logic [7:0] idx);
    rd_take && haddr == {22'h0, idx, 2'h0};
  endsequence

  property p_ready;
    hreadyout == 1'b1 && hresp == 1'b0;
  endproperty
  property p_hold;
    !rd_take |=> $stable(hrdata);
  endproperty
  property p_upper;
    rd_take |=> hrdata[31:8] == 24'h0;
  endproperty
  property p_bad;
    rd_take && (haddr[1:0] != 2'h0 || haddr[31:10] != 22'h0) |=> hrdata == 32'h0;
  endproperty
  property p_filt;
    s_rd(timer2_pkg::IDX_CAPTURE_FILTER_CONTROL) |=> (hrdata[7:0] & 8'h8F) == 8'h00;
  endproperty
  property p_edge;
    s_rd(timer2_pkg::IDX_EDGE_SELECT) |=> hrdata[7:6] == 2'h0;
  endproperty
  property p_cap;
    s_rd(timer2_pkg::IDX_CAPTURE_CONTROL) |=> !hrdata[7] && !hrdata[3];
  endproperty
  property p_mode;
    s_rd(timer2_pkg::IDX_TIMER_MODE) |=> hrdata[6:4] == 3'h0;
  endproperty
  property p_ctl;
    s_rd(timer2_pkg::IDX_TIMER_CONTROL) |=> (hrdata[7:0] & 8'h7A) == 8'h00;
  endproperty

  a_ready: assert property (p_ready) else $error("bus not ready or not okay");
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  a_bad: assert property (p_bad) else $error("unmapped read not zero");
  a_filt: assert property (p_filt) else $error("filter reserved bits set");
  a_edge: assert property (p_edge) else $error("edge select reserved bits set");
  a_cap: assert property (p_cap) else $error("capture control reserved set");
  a_mode: assert property (p_mode) else $error("mode reserved bits set");
  a_ctl: assert property (p_ctl) else $error("control reserved bits set");
endmodule : timer2_capture_reload_compare_props

// >>> dv/timer2_capture_reload_compare_tb.sv
module timer2_capture_reload_compare_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CC = timer2_pkg::IDX_CAPTURE_CONTROL;
  localparam logic [7:0] ES = timer2_pkg::IDX_EDGE_SELECT;
  localparam logic [7:0] FC = timer2_pkg::IDX_CAPTURE_FILTER_CONTROL;
  localparam logic [7:0] TC = timer2_pkg::IDX_TIMER_CONTROL;
  localparam logic [7:0] TM = timer2_pkg::IDX_TIMER_MODE;
  localparam logic [7:0] RL = timer2_pkg::IDX_RELOAD_COMPARE_LOW;
  localparam logic [7:0] RH = timer2_pkg::IDX_RELOAD_COMPARE_HIGH;
  localparam logic [7:0] CL = timer2_pkg::IDX_COUNTER_LOW;
  localparam logic [7:0] CH = timer2_pkg::IDX_COUNTER_HIGH;
  logic [7:0] res [6] = '{8'hE4, 8'hE5, 8'hE6, 8'hE7, 8'hED, 8'hEE};
  logic [7:0] modes [8] = '{8'h89, 8'h00, 8'h08, 8'h81, 8'h82, 8'h83, 8'h82, 8'h83};
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdv, lfsr_r;
  logic [1:0] htrans;
  logic [2:0] hsize, capture_in;
  logic [15:0] cnt, cv;
  int bad_count, n_tests;

  // ==========================================================
  // Design, bus ready looped back, clock
  // ==========================================================
  assign hready = hreadyout;
  timer2_capture_reload_compare #(.TICK_DIV(1)) uut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_in(capture_in)
  );
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  // ==========================================================
  // Expectations and report
  // ==========================================================
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic hit(input logic [1:0] c, input logic rise);
    return c == 2'h2 || (c == 2'h1 && rise) || (c == 2'h0 && !rise);
  endfunction : hit
  function automatic logic [15:0] after_cap(input logic [7:0] m, input int ch,
    input logic [15:0] v);
    if (m[3])
      return 16'h0000;
    if (m[7] && int'(m[1:0]) == ch + 1)
      return 16'h1234;
    return v;
  endfunction : after_cap
  task automatic end_sim;
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // ==========================================================
  // Bus cycles, entered just after a rising edge
  // ==========================================================
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        bad_count++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
    rdv = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, {22'h0, i, 2'h0}, d);
  endtask : wr
  task automatic rd(input logic [7:0] i);
    xfer(1'b0, {22'h0, i, 2'h0}, 8'h00);
  endtask : rd
  task automatic set_cnt(input logic [15:0] v);
    wr(CL, v[7:0]);
    wr(CH, v[15:8]);
  endtask : set_cnt
  task automatic rd_cnt;
    rd(CL);
    cnt[7:0] = rdv[7:0];
    rd(CH);
    cnt[15:8] = rdv[7:0];
  endtask : rd_cnt

  // ==========================================================
  // Capture scenarios, counter stopped so results are exact
  // ==========================================================
  task automatic edge_run(input int ch, input logic [1:0] c, input logic en);
    lfsr_r = lfsr(lfsr_r);
    cv = lfsr_r[15:0];
    set_cnt(cv);
    wr(ES, 8'(c) << (2 * ch));
    wr(CC, 8'(en) << (4 + ch));
    for (int r = 1; r >= 0; r--)
    begin
      capture_in[ch] <= r[0];
      repeat (12) @(posedge hclk);
      rd(CC);
      chk("capture flag", {31'h0, en && hit(c, r[0])}, {31'h0, rdv[ch]});
      if (en && hit(c, r[0]))
      begin
        rd(res[2 * ch]);
        chk("result low", cv[7:0], rdv);
        rd(res[2 * ch + 1]);
        chk("result high", cv[15:8], rdv);
      end
      wr(CC, 8'(en) << (4 + ch));
    end
  endtask : edge_run
  task automatic glitch(input logic filt, input int len, input logic e);
    wr(FC, {3'h0, filt, 4'h0});
    wr(ES, 8'h02);
    repeat (12) @(posedge hclk);
    wr(CC, 8'h10);
    capture_in[0] <= 1'b1;
    repeat (len) @(posedge hclk);
    capture_in[0] <= 1'b0;
    repeat (16) @(posedge hclk);
    rd(CC);
    chk("filtered flag", {31'h0, e}, {31'h0, rdv[0]});
  endtask : glitch

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata, capture_in} = '0;
    hsize = 3'h2;
    lfsr_r = 32'h492F;
    bad_count = 0;
    n_tests = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (res[i])
    begin
      rd(res[i]);
      chk("reset value", 32'h0, rdv);
      lfsr_r = lfsr(lfsr_r);
      wr(res[i], lfsr_r[7:0]);
      rd(res[i]);
      chk("result byte", {24'h0, lfsr_r[7:0]}, rdv);
    end
    rd(FC);
    chk("filter reset", 32'h0, rdv);
    lfsr_r = lfsr(lfsr_r);
    wr(FC, lfsr_r[7:0]);
    rd(FC);
    chk("filter control", {24'h0, lfsr_r[7:0] & 8'h70}, rdv);
    wr(FC, 8'h70);
    xfer(1'b0, {22'h0, FC, 2'h1}, 8'h00);
    chk("misaligned read", 32'h0, rdv);
    xfer(1'b1, {22'h1, FC, 2'h0}, 8'h00);
    rd(FC);
    chk("unmapped write", 32'h70, rdv);
    wr(FC, 8'h00);
    for (int ch = 0; ch < 3; ch++)
      for (int c = 0; c < 4; c++)
        edge_run(ch, c[1:0], 1'b1);
    edge_run(1, 2'h2, 1'b0);
    wr(RL, 8'h34);
    wr(RH, 8'h12);
    foreach (modes[i])
    begin
      wr(TM, modes[i]);
      edge_run(i % 3, 2'h1, 1'b1);
      rd_cnt();
      chk("counter after capture", after_cap(modes[i], i % 3, cv), cnt);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(TM, k == 0 ? 8'h80 : 8'h00);
      set_cnt(16'hFFF0);
      wr(TC, 8'h04);
      repeat (40) @(posedge hclk);
      wr(TC, 8'h00);
      rd_cnt();
      chk("overflow wrap", 32'h1, {31'h0, k == 0 ? cnt >= 16'h1234 && cnt < 16'h1274
        : cnt < 16'h0040});
    end
    wr(RL, 8'h20);
    wr(RH, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      if (k == 2)
        wr(RH, 8'h80);
      wr(TM, k == 0 ? 8'h84 : 8'h80);
      set_cnt(16'h0000);
      wr(TC, 8'h05);
      repeat (100) @(posedge hclk);
      rd(TC);
      chk("match flag", {31'h0, k < 2}, {31'h0, rdv[7]});
      wr(TC, 8'h01);
      rd_cnt();
      chk("cleared on match", {31'h0, k == 0}, {31'h0, cnt <= 16'h0020});
    end
    glitch(1'b1, 3, 1'b0);
    glitch(1'b0, 3, 1'b1);
    glitch(1'b1, 8, 1'b1);
    end_sim();
  end
endmodule : timer2_capture_reload_compare_tb

bind timer2_capture_reload_compare timer2_capture_reload_compare_props
  #(.TICK_DIV(TICK_DIV)) u_props
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
);

// >>> logic/ahb_port.sv
// ============================================================
// AHB-Lite slave front end: zero wait states, always OKAY
// ============================================================
module ahb_port
(
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready, from flop
  output logic hresp, // Response, from flop
  output logic rd_pulse, // Read taken this cycle
  output logic [7:0] rd_idx, // Read register index
  output logic wr_pulse, // Write data phase, registered
  output logic [7:0] wr_idx // Write register index
);
  logic taken;
  logic [7:0] idx;

  // Address phase decode; misaligned or high addresses map to index 0
  assign taken = hsel & htrans[1] & hready;
  assign idx = (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0) ? haddr[9:2] : 8'h00;
  assign rd_pulse = taken & ~hwrite;
  assign rd_idx = idx;

  // Write address held into data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pulse <= 1'b0;
      wr_idx <= 8'h00;
    end
    else
    begin
      wr_pulse <= taken & hwrite;
      wr_idx <= idx;
    end
  end

  // Never waits, never errors
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
endmodule : ahb_port

// >>> logic/capture_channel.sv
// ============================================================
// One capture input: synchroniser, glitch filter, edge select
// ============================================================
module capture_channel
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, active low
  input wire logic pin, // Asynchronous capture pin
  input wire logic filter_en, // Glitch filter on
  input wire logic [1:0] edge_sel, // Edge selection code
  output logic edge_evt // Selected edge, one-cycle pulse
);
  localparam int CW = $clog2(timer2_pkg::FILTER_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(timer2_pkg::FILTER_CYCLES - 1);

  logic sync1_r;
  logic sync2_r;
  logic filt_r;
  logic [CW-1:0] stable_r;
  logic level;
  logic prev_r;
  logic rise;
  logic fall;

  // Two-flop synchroniser
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
    end
  end

  // Level accepted only after holding for the full filter time
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      filt_r <= 1'b0;
      stable_r <= '0;
    end
    else if (sync2_r == filt_r)
      stable_r <= '0;
    else if (stable_r == LAST)
    begin
      filt_r <= sync2_r;
      stable_r <= '0;
    end
    else
      stable_r <= stable_r + 1'b1;
  end

  assign level = filter_en ? filt_r : sync2_r;

  // Previous level for edge detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prev_r <= 1'b0;
    else
      prev_r <= level;
  end

  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;

  // Edge decode; reserved code never triggers
  always_comb
  begin
    case (edge_sel)
      timer2_pkg::EDGE_FALLING: edge_evt = fall;
      timer2_pkg::EDGE_RISING: edge_evt = rise;
      timer2_pkg::EDGE_BOTH: edge_evt = rise | fall;
      default: edge_evt = 1'b0;
    endcase
  end
endmodule : capture_channel

// >>> logic/timer2_capture_reload_compare.sv
// Operation
// - Edge code 10 captures on both edges; code 11 is reserved and never triggers.
// - Filter control bits 6, 5, 4 enable the glitch filter of channels 2, 1, 0.
// - Each channel keeps a 16-bit result in a low and a high byte, both read/write.
// - Reload-versus-compare select 0 with reload enable 1 gives auto-reload mode.
// - In auto-reload mode a reload event copies the reload bytes into the counter.
// - Mode bits 1:0 choose overflow or one capture channel as reload trigger.
// - With capture-clear set a capture only zeroes the counter, never reloads it.
// - Select 1 gives compare mode whatever reload enable holds.
// - In compare mode a counter equal to the compare value sets control bit 7.
// - With match-clear set the counter returns to zero after each match.
// - A selected edge on an enabled channel stores the counter and sets its flag.
// - Edge code 00 captures falling edges and 01 rising edges.
// - An enabled filter rejects glitches shorter than four clocks.
// - With capture-clear set the counter is zeroed right after being captured.
//
// Added by the designer: register access over AHB-Lite.
module timer2_capture_reload_compare
#(
  parameter int TICK_DIV = 1 // Clocks per timer tick
)
(
  input wire logic hclk, // Clock, 200 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp, // AHB response
  input wire logic [2:0] capture_in // Capture pins
);
  localparam int NCH = timer2_pkg::NUM_CHANNELS;
  localparam int DW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  // ==========================================================
  // Parameter check
  // ==========================================================
  if (TICK_DIV < 1)
  begin : g_bad_div
    $error("TICK_DIV must be at least 1");
  end

  // ==========================================================
  // Bus front end
  // ==========================================================
  logic rd_pulse;
  logic [7:0] rd_idx;
  logic wr_pulse;
  logic [7:0] wr_idx;
  logic [7:0] wdat;

  ahb_port u_ahb
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .rd_pulse(rd_pulse),
    .rd_idx(rd_idx),
    .wr_pulse(wr_pulse),
    .wr_idx(wr_idx)
  );

  assign wdat = hwdata[7:0];

  // ==========================================================
  // Registers
  // ==========================================================
  logic [NCH-1:0] cap_en_r;
  logic [NCH-1:0] capture_flag_r;
  logic [2*NCH-1:0] edge_sel_r;
  logic [NCH-1:0] filter_en_r;
  logic [15:0] result_r [NCH];
  logic [15:0] reload_compare_r;
  logic [15:0] counter_r;
  logic [15:0] counter_nxt;
  logic run_r;
  logic compare_mode_select_r;
  logic compare_match_flag_r;
  logic reload_enable_r;
  logic capture_clear_counter_r;
  logic match_clear_counter_r;
  logic [1:0] reload_trigger_select_r;
  logic [DW-1:0] div_r;
  logic [NCH-1:0] edge_evt;
  logic [NCH-1:0] cap_evt;
  logic tick;
  logic overflow;
  logic match;
  logic reload_mode;
  logic trig_evt;
  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_pulse && (wr_idx == idx);
  endfunction : wr_hit

  // ==========================================================
  // Capture channels
  // ==========================================================
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    capture_channel u_ch
    (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(capture_in[i]),
      .filter_en(filter_en_r[i]),
      .edge_sel(edge_sel_r[2*i+1:2*i]),
      .edge_evt(edge_evt[i])
    );
    assign cap_evt[i] = edge_evt[i] & cap_en_r[i];
  end

  // ==========================================================
  // Capture result pairs: capture beats a software write
  // ==========================================================
  logic [7:0] res_lo_idx [NCH];
  logic [7:0] res_hi_idx [NCH];
  assign res_lo_idx[0] = timer2_pkg::IDX_CAPTURE0_RESULT_LOW;
  assign res_hi_idx[0] = timer2_pkg::IDX_CAPTURE0_RESULT_HIGH;
  assign res_lo_idx[1] = timer2_pkg::IDX_CAPTURE1_RESULT_LOW;
  assign res_hi_idx[1] = timer2_pkg::IDX_CAPTURE1_RESULT_HIGH;
  assign res_lo_idx[2] = timer2_pkg::IDX_CAPTURE2_RESULT_LOW;
  assign res_hi_idx[2] = timer2_pkg::IDX_CAPTURE2_RESULT_HIGH;
  for (genvar i = 0; i < NCH; i++)
  begin : g_res
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        result_r[i] <= timer2_pkg::COUNT_RESET;
      else if (cap_evt[i])
        result_r[i] <= counter_r;
      else if (wr_hit(res_lo_idx[i]))
        result_r[i][7:0] <= wdat;
      else if (wr_hit(res_hi_idx[i]))
        result_r[i][15:8] <= wdat;
    end
  end

  // ==========================================================
  // Capture control: enables and sticky flags, set beats clear
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cap_en_r <= '0;
      capture_flag_r <= '0;
    end
    else if (wr_hit(timer2_pkg::IDX_CAPTURE_CONTROL))
    begin
      cap_en_r <= wdat[timer2_pkg::CAP_ENABLE_LSB +: NCH];
      capture_flag_r <= wdat[timer2_pkg::CAP_FLAG_LSB +: NCH] | cap_evt;
    end
    else
      capture_flag_r <= capture_flag_r | cap_evt;
  end

  // Edge select and filter enables
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      edge_sel_r <= '0;
      filter_en_r <= '0;
    end
    else
    begin
      if (wr_hit(timer2_pkg::IDX_EDGE_SELECT))
        edge_sel_r <= wdat[2*NCH-1:0];
      if (wr_hit(timer2_pkg::IDX_CAPTURE_FILTER_CONTROL))
        filter_en_r <= wdat[timer2_pkg::FILTER_ENABLE_LSB +: NCH];
    end
  end

  // ==========================================================
  // Timer control and mode
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run_r <= 1'b0;
      compare_mode_select_r <= 1'b0;
    end
    else if (wr_hit(timer2_pkg::IDX_TIMER_CONTROL))
    begin
      run_r <= wdat[timer2_pkg::CTRL_RUN_BIT];
      compare_mode_select_r <= wdat[timer2_pkg::CTRL_COMPARE_MODE_BIT];
    end
  end

  // Compare match flag, set beats a software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      compare_match_flag_r <= 1'b0;
    else if (match)
      compare_match_flag_r <= 1'b1;
    else if (wr_hit(timer2_pkg::IDX_TIMER_CONTROL))
      compare_match_flag_r <= wdat[timer2_pkg::CTRL_MATCH_FLAG_BIT];
  end

  // Mode register fields
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reload_enable_r <= 1'b0;
      capture_clear_counter_r <= 1'b0;
      match_clear_counter_r <= 1'b0;
      reload_trigger_select_r <= timer2_pkg::TRIGGER_OVERFLOW;
    end
    else if (wr_hit(timer2_pkg::IDX_TIMER_MODE))
    begin
      reload_enable_r <= wdat[timer2_pkg::MODE_RELOAD_ENABLE_BIT];
      capture_clear_counter_r <= wdat[timer2_pkg::MODE_CAPTURE_CLEAR_BIT];
      match_clear_counter_r <= wdat[timer2_pkg::MODE_MATCH_CLEAR_BIT];
      reload_trigger_select_r <= wdat[timer2_pkg::MODE_TRIGGER_LSB +: 2];
    end
  end

  // Reload / compare value pair
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      reload_compare_r <= timer2_pkg::COUNT_RESET;
    else if (wr_hit(timer2_pkg::IDX_RELOAD_COMPARE_LOW))
      reload_compare_r[7:0] <= wdat;
    else if (wr_hit(timer2_pkg::IDX_RELOAD_COMPARE_HIGH))
      reload_compare_r[15:8] <= wdat;
  end

  // ==========================================================
  // Tick divider
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_r <= '0;
    else if (!run_r || div_r == DW'(TICK_DIV - 1))
      div_r <= '0;
    else
      div_r <= div_r + 1'b1;
  end

  assign tick = run_r && (div_r == DW'(TICK_DIV - 1));

  // ==========================================================
  // Counter events
  // ==========================================================
  assign reload_mode = ~compare_mode_select_r & reload_enable_r;
  assign overflow = tick && (counter_r == 16'hFFFF);
  assign match = compare_mode_select_r && tick && (counter_r == reload_compare_r);

  // Reload trigger: overflow or one channel's capture
  always_comb
  begin
    case (reload_trigger_select_r)
      timer2_pkg::TRIGGER_OVERFLOW: trig_evt = overflow;
      2'h1: trig_evt = cap_evt[0];
      2'h2: trig_evt = cap_evt[1];
      2'h3: trig_evt = cap_evt[2];
      default: trig_evt = 1'b0;
    endcase
  end

  // Counter next value, in priority order
  always_comb
  begin
    if (wr_hit(timer2_pkg::IDX_COUNTER_LOW))
      counter_nxt = {counter_r[15:8], wdat};
    else if (wr_hit(timer2_pkg::IDX_COUNTER_HIGH))
      counter_nxt = {wdat, counter_r[7:0]};
    else if ((|cap_evt) && capture_clear_counter_r)
      counter_nxt = timer2_pkg::COUNT_RESET;
    else if (reload_mode && trig_evt)
      counter_nxt = reload_compare_r;
    else if (match && match_clear_counter_r)
      counter_nxt = timer2_pkg::COUNT_RESET;
    else if (tick)
      counter_nxt = counter_r + 16'h0001;
    else
      counter_nxt = counter_r;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      counter_r <= timer2_pkg::COUNT_RESET;
    else
      counter_r <= counter_nxt;
  end

  // ==========================================================
  // Read data, registered in the address phase
  // ==========================================================
  logic [7:0] rd_byte;
  always_comb
  begin
    case (rd_idx)
      timer2_pkg::IDX_CAPTURE_CONTROL: rd_byte = {1'b0, cap_en_r, 1'b0, capture_flag_r};
      timer2_pkg::IDX_EDGE_SELECT: rd_byte = {2'h0, edge_sel_r};
      timer2_pkg::IDX_CAPTURE_FILTER_CONTROL: rd_byte = {1'b0, filter_en_r, 4'h0};
      timer2_pkg::IDX_TIMER_CONTROL:
        rd_byte = {compare_match_flag_r, 4'h0, run_r, 1'b0, compare_mode_select_r};
      timer2_pkg::IDX_TIMER_MODE:
        rd_byte = {reload_enable_r, 3'h0, capture_clear_counter_r,
                   match_clear_counter_r, reload_trigger_select_r};
      timer2_pkg::IDX_RELOAD_COMPARE_LOW: rd_byte = reload_compare_r[7:0];
      timer2_pkg::IDX_RELOAD_COMPARE_HIGH: rd_byte = reload_compare_r[15:8];
      timer2_pkg::IDX_COUNTER_LOW: rd_byte = counter_r[7:0];
      timer2_pkg::IDX_COUNTER_HIGH: rd_byte = counter_r[15:8];
      timer2_pkg::IDX_CAPTURE0_RESULT_LOW: rd_byte = result_r[0][7:0];
      timer2_pkg::IDX_CAPTURE0_RESULT_HIGH: rd_byte = result_r[0][15:8];
      timer2_pkg::IDX_CAPTURE1_RESULT_LOW: rd_byte = result_r[1][7:0];
      timer2_pkg::IDX_CAPTURE1_RESULT_HIGH: rd_byte = result_r[1][15:8];
      timer2_pkg::IDX_CAPTURE2_RESULT_LOW: rd_byte = result_r[2][7:0];
      timer2_pkg::IDX_CAPTURE2_RESULT_HIGH: rd_byte = result_r[2][15:8];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_pulse)
      hrdata <= {24'h000000, rd_byte};
  end
endmodule : timer2_capture_reload_compare

// >>> logic/timer2_pkg.sv
package timer2_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [7:0] IDX_CAPTURE_CONTROL = 8'h92;
  localparam logic [7:0] IDX_EDGE_SELECT = 8'h93;
  localparam logic [7:0] IDX_CAPTURE_FILTER_CONTROL = 8'h94;
  localparam logic [7:0] IDX_TIMER_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_TIMER_MODE = 8'hC9;
  localparam logic [7:0] IDX_RELOAD_COMPARE_LOW = 8'hCA;
  localparam logic [7:0] IDX_RELOAD_COMPARE_HIGH = 8'hCB;
  localparam logic [7:0] IDX_COUNTER_LOW = 8'hCC;
  localparam logic [7:0] IDX_COUNTER_HIGH = 8'hCD;
  localparam logic [7:0] IDX_CAPTURE0_RESULT_LOW = 8'hE4;
  localparam logic [7:0] IDX_CAPTURE0_RESULT_HIGH = 8'hE5;
  localparam logic [7:0] IDX_CAPTURE1_RESULT_LOW = 8'hE6;
  localparam logic [7:0] IDX_CAPTURE1_RESULT_HIGH = 8'hE7;
  localparam logic [7:0] IDX_CAPTURE2_RESULT_LOW = 8'hED;
  localparam logic [7:0] IDX_CAPTURE2_RESULT_HIGH = 8'hEE;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CAP_ENABLE_LSB = 4;
  localparam int CAP_FLAG_LSB = 0;
  localparam int FILTER_ENABLE_LSB = 4;
  localparam int CTRL_MATCH_FLAG_BIT = 7;
  localparam int CTRL_RUN_BIT = 2;
  localparam int CTRL_COMPARE_MODE_BIT = 0;
  localparam int MODE_RELOAD_ENABLE_BIT = 7;
  localparam int MODE_CAPTURE_CLEAR_BIT = 3;
  localparam int MODE_MATCH_CLEAR_BIT = 2;
  localparam int MODE_TRIGGER_LSB = 0;

  // ==========================================================
  // Encodings, reset values and timing
  // ==========================================================
  localparam logic [1:0] EDGE_FALLING = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] TRIGGER_OVERFLOW = 2'h0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam int FILTER_CYCLES = 4;
  localparam int NUM_CHANNELS = 3;

endpackage : timer2_pkg
